// ==== hw/tmg_top.v ====
// Contract
// - two paths, each with 5-bit code register
// - divider per path sets sample rate
// - modulo-28 scanner walks 28-entry sine table
// - sine mode passes all six bits
// - square mode keeps only table msb
// - pacifier tone from row table msb
// - tone output dual; pacifier single square
// - illegal code stops both paths and the pacifier; tone pin stays enabled
// - control layout, low bits zero, reset zero
// - two mode bits pick four modes
// - pacifier active in square 2/3 only
// - pacifier level follows enables and legality
// - tone output tristate until enabled
// - stop forces pacifier high, tone tristate
// - square 3: column melody plus pacifier
// - row enable runs the row path
// - column enable runs the column path
// - illegal code: pacifier high, output mid-scale
// - mode codes map outputs per table
// - clearing a path enable resets that path's divider and scanner
// - dialling codes legal only in own register
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "tmg_consts.vh"

module tmg_top #(
  parameter TONE_DIV = `TMG_TONE_DIV
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire stop_mode,
  output reg [5:0] row_dac,
  output reg [5:0] col_dac,
  output reg tone_out_oe_n,
  output reg pacifier_out
);

  // ----------------------------------------
  // code legality
  // ----------------------------------------
  // row dialling codes 00-03 belong to row only, 10-13 to column only
  function tmg_code_ok;
    input [4:0] c;
    input is_col;
    begin
      if (c[4:2] == 3'b000)
        tmg_code_ok = !is_col;
      else if (c[4:2] == 3'b100)
        tmg_code_ok = is_col;
      else
        tmg_code_ok = 1'b1;
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [4:0] row_tone_code;
  reg [4:0] column_tone_code;
  reg mode_select_hi;
  reg mode_select_lo;
  reg row_path_enable;
  reg column_path_enable;
  reg tone_out_enable;
  reg [3:0] pre_cnt;
  reg tone_tick;

  wire setup_ph;
  wire access_ph;
  wire wr_en;
  wire [1:0] mode;
  wire codes_legal;
  wire row_run;
  wire col_run;
  wire [5:0] row_sample;
  wire [5:0] col_sample;
  wire [9:0] path_code;
  wire [1:0] path_run;
  wire [11:0] path_sample;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable && pready;
  assign wr_en = access_ph && pwrite;
  assign mode = {mode_select_hi, mode_select_lo};

  // register writes take effect at the completing edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_tone_code <= `TMG_RST_CODE;
      column_tone_code <= `TMG_RST_CODE;
      {mode_select_hi, mode_select_lo, row_path_enable, column_path_enable, tone_out_enable} <= `TMG_RST_CONTROL;
    end else if (wr_en) begin
      case (paddr)
        `TMG_ADDR_ROW_CODE: begin
          row_tone_code <= pwdata[4:0];
        end
        `TMG_ADDR_COL_CODE: begin
          column_tone_code <= pwdata[4:0];
        end
        `TMG_ADDR_CONTROL: begin
          mode_select_hi <= pwdata[`TMG_CTL_MODE_HI];
          mode_select_lo <= pwdata[`TMG_CTL_MODE_LO];
          row_path_enable <= pwdata[`TMG_CTL_ROW_EN];
          column_path_enable <= pwdata[`TMG_CTL_COL_EN];
          tone_out_enable <= pwdata[`TMG_CTL_OUT_EN];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  // one wait-free access phase: pready rises the cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup_ph) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      case (paddr)
        `TMG_ADDR_ROW_CODE: prdata <= {27'h0000000, row_tone_code};
        `TMG_ADDR_COL_CODE: prdata <= {27'h0000000, column_tone_code};
        `TMG_ADDR_CONTROL: prdata <= {24'h000000, mode, row_path_enable, column_path_enable,
                                       tone_out_enable, 3'h0};
        `TMG_ADDR_STATUS: prdata <= {28'h0000000, pacifier_out, col_run, row_run, codes_legal};
        default: pslverr <= 1'b1;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // tone clock enable
  // ----------------------------------------
  // one pulse per tone clock period from pclk
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 4'h0;
      tone_tick <= 1'b0;
    end else if (pre_cnt == TONE_DIV[3:0] - 4'h1) begin
      pre_cnt <= 4'h0;
      tone_tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 4'h1;
      tone_tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // path control
  // ----------------------------------------
  // validator checks both registers at all times
  assign codes_legal = tmg_code_ok(row_tone_code, 1'b0) && tmg_code_ok(column_tone_code, 1'b1);
  // row runs only when enabled and legal
  assign row_run = row_path_enable && codes_legal && !stop_mode;
  // column runs only when enabled and legal
  assign col_run = column_path_enable && codes_legal && !stop_mode;

  assign path_code = {column_tone_code, row_tone_code};
  assign path_run = {col_run, row_run};
  assign row_sample = path_sample[5:0];
  assign col_sample = path_sample[11:6];

  // one divider and scanner per path
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_path
      tmg_path u_path (
        .pclk(pclk),
        .presetn(presetn),
        .tone_tick(tone_tick),
        .run(path_run[gi]),
        .code(path_code[gi*5 +: 5]),
        .sample(path_sample[gi*6 +: 6])
      );
    end
  endgenerate

  // ----------------------------------------
  // output shaping
  // ----------------------------------------
  reg [5:0] next_row_dac;
  reg [5:0] next_col_dac;
  reg next_pacifier;

  // converter codes and pacifier level per mode
  always @* begin
    next_row_dac = `TMG_DAC_MID;
    next_col_dac = `TMG_DAC_MID;
    next_pacifier = 1'b1;
    case (mode)
      `TMG_MODE_SINE: begin
        if (row_run)
          next_row_dac = row_sample;
        if (col_run)
          next_col_dac = col_sample;
      end
      `TMG_MODE_SQ1, `TMG_MODE_SQ2: begin
        if (row_run)
          next_row_dac = row_sample & `TMG_DAC_MSB;
        if (col_run)
          next_col_dac = col_sample & `TMG_DAC_MSB;
      end
      `TMG_MODE_SQ3: begin
        // column melody alone on the tone output
        if (col_run)
          next_col_dac = col_sample & `TMG_DAC_MSB;
      end
      default: begin
      end
    endcase
    // pacifier is row msb in square 2/3
    if (mode_select_hi && row_run)
      next_pacifier = row_sample[5];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_dac <= `TMG_DAC_MID;
      col_dac <= `TMG_DAC_MID;
      tone_out_oe_n <= 1'b1;
      pacifier_out <= 1'b1;
    end else begin
      row_dac <= next_row_dac;
      col_dac <= next_col_dac;
      tone_out_oe_n <= !(tone_out_enable && !stop_mode);
      pacifier_out <= next_pacifier;
    end
  end

endmodule

// ==== hw/tmg_consts.vh ====
`ifndef TMG_CONSTS_VH
`define TMG_CONSTS_VH

// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define TMG_IDX_ROW_CODE 8'h0D
`define TMG_IDX_COL_CODE 8'h0E
`define TMG_IDX_CONTROL 8'h0F
`define TMG_IDX_STATUS 8'h10
`define TMG_ADDR_ROW_CODE 12'h034
`define TMG_ADDR_COL_CODE 12'h038
`define TMG_ADDR_CONTROL 12'h03C
`define TMG_ADDR_STATUS 12'h040

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define TMG_CTL_MODE_HI 7
`define TMG_CTL_MODE_LO 6
`define TMG_CTL_ROW_EN 5
`define TMG_CTL_COL_EN 4
`define TMG_CTL_OUT_EN 3
`define TMG_CODE_W 5
`define TMG_DAC_W 6
`define TMG_RST_CONTROL 5'h00
`define TMG_RST_CODE 5'h00
`define TMG_DAC_MID 6'h20
`define TMG_DAC_MSB 6'h20

// ----------------------------------------
// mode encodings
// ----------------------------------------
`define TMG_MODE_SINE 2'h0
`define TMG_MODE_SQ1 2'h1
`define TMG_MODE_SQ2 2'h2
`define TMG_MODE_SQ3 2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define TMG_PCLK_HZ 20000000
`define TMG_TONE_CLK_HZ 1789772
`define TMG_TONE_DIV ((`TMG_PCLK_HZ + `TMG_TONE_CLK_HZ / 2) / `TMG_TONE_CLK_HZ)
`define TMG_STEPS 28

`endif

// ==== hw/tmg_path.v ====
`timescale 1ns/1ps
`include "tmg_consts.vh"

module tmg_path #(
  parameter STEPS = `TMG_STEPS
) (
  input wire pclk,
  input wire presetn,
  input wire tone_tick,
  input wire run,
  input wire [4:0] code,
  output wire [5:0] sample
);

  // ----------------------------------------
  // divisor and sine lookups
  // ----------------------------------------
  // tone clock cycles per table step for each code
  function [6:0] tmg_divisor;
    input [4:0] c;
    begin
      case (c)
        5'h00: tmg_divisor = 7'h5C;
        5'h01: tmg_divisor = 7'h53;
        5'h02: tmg_divisor = 7'h4B;
        5'h03: tmg_divisor = 7'h44;
        5'h04: tmg_divisor = 7'h67;
        5'h05: tmg_divisor = 7'h61;
        5'h06: tmg_divisor = 7'h5C;
        5'h07: tmg_divisor = 7'h56;
        5'h08: tmg_divisor = 7'h52;
        5'h09: tmg_divisor = 7'h4D;
        5'h0A: tmg_divisor = 7'h49;
        5'h0B: tmg_divisor = 7'h45;
        5'h0C: tmg_divisor = 7'h41;
        5'h0D: tmg_divisor = 7'h3D;
        5'h0E: tmg_divisor = 7'h3A;
        5'h0F: tmg_divisor = 7'h36;
        5'h10: tmg_divisor = 7'h35;
        5'h11: tmg_divisor = 7'h30;
        5'h12: tmg_divisor = 7'h2B;
        5'h13: tmg_divisor = 7'h27;
        5'h14: tmg_divisor = 7'h33;
        5'h15: tmg_divisor = 7'h30;
        5'h16: tmg_divisor = 7'h2E;
        5'h17: tmg_divisor = 7'h2B;
        5'h18: tmg_divisor = 7'h29;
        5'h19: tmg_divisor = 7'h26;
        5'h1A: tmg_divisor = 7'h24;
        5'h1B: tmg_divisor = 7'h22;
        5'h1C: tmg_divisor = 7'h20;
        5'h1D: tmg_divisor = 7'h1F;
        5'h1E: tmg_divisor = 7'h1D;
        default: tmg_divisor = 7'h1B;
      endcase
    end
  endfunction

  // staircase sine, step 0 is the dc level
  function [5:0] tmg_sine;
    input [4:0] s;
    begin
      case (s)
        5'h00: tmg_sine = 6'h20;
        5'h01: tmg_sine = 6'h27;
        5'h02: tmg_sine = 6'h2D;
        5'h03: tmg_sine = 6'h33;
        5'h04: tmg_sine = 6'h38;
        5'h05: tmg_sine = 6'h3C;
        5'h06: tmg_sine = 6'h3E;
        5'h07: tmg_sine = 6'h3F;
        5'h08: tmg_sine = 6'h3E;
        5'h09: tmg_sine = 6'h3C;
        5'h0A: tmg_sine = 6'h38;
        5'h0B: tmg_sine = 6'h33;
        5'h0C: tmg_sine = 6'h2D;
        5'h0D: tmg_sine = 6'h27;
        5'h0E: tmg_sine = 6'h1F;
        5'h0F: tmg_sine = 6'h19;
        5'h10: tmg_sine = 6'h13;
        5'h11: tmg_sine = 6'h0D;
        5'h12: tmg_sine = 6'h08;
        5'h13: tmg_sine = 6'h04;
        5'h14: tmg_sine = 6'h02;
        5'h15: tmg_sine = 6'h01;
        5'h16: tmg_sine = 6'h02;
        5'h17: tmg_sine = 6'h04;
        5'h18: tmg_sine = 6'h08;
        5'h19: tmg_sine = 6'h0D;
        5'h1A: tmg_sine = 6'h13;
        default: tmg_sine = 6'h19;
      endcase
    end
  endfunction

  // ----------------------------------------
  // divider and scanner
  // ----------------------------------------
  reg [6:0] div_cnt;
  reg [4:0] scan;
  wire [6:0] div_last;

  assign div_last = tmg_divisor(code) - 7'h01;
  assign sample = tmg_sine(scan);

  // both counters sit in reset while the path is off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 7'h00;
      scan <= 5'h00;
    end else if (!run) begin
      div_cnt <= 7'h00;
      scan <= 5'h00;
    end else if (tone_tick) begin
      if (div_cnt >= div_last) begin
        div_cnt <= 7'h00;
        if (scan == STEPS - 1)
          scan <= 5'h00;
        else
          scan <= scan + 5'h01;
      end else begin
        div_cnt <= div_cnt + 7'h01;
      end
    end
  end

endmodule

// ==== dv/tmg_top_monitor.sv ====
`timescale 1ns/1ps
`include "tmg_consts.vh"

module tmg_top_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire stop_mode,
  input wire [5:0] row_dac,
  input wire [5:0] col_dac,
  input wire tone_out_oe_n,
  input wire pacifier_out
);
  logic [7:0] ctl;
  logic [2:0] age;
  wire settled = (age == 3'h7);
  wire [1:0] mode = ctl[7:6];

  // shadow of the control register and cycles since its last write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 8'h00;
      age <= 3'h0;
    end else if (psel && penable && pready && pwrite && paddr == `TMG_ADDR_CONTROL) begin
      ctl <= pwdata[7:0];
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // bus and pin checks
  // ----------------------------------------
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("pready held past one cycle");
  AST_ERR_IN_ACCESS: assert property (pslverr |-> pready && psel && penable) else $error("stray pslverr");
  AST_STOP_OE: assert property (stop_mode |=> tone_out_oe_n) else $error("tone pin driven in stop");
  AST_STOP_PAC: assert property (stop_mode [*2] |=> pacifier_out) else $error("pacifier low in stop");
  AST_OE_FOLLOWS: assert property (settled && !stop_mode && !$past(stop_mode)
    |-> tone_out_oe_n == !ctl[`TMG_CTL_OUT_EN]) else $error("tone enable mismatch");
  AST_SQUARE_MSB: assert property (settled && mode != `TMG_MODE_SINE
    |-> row_dac[4:0] == 5'h00 && col_dac[4:0] == 5'h00) else $error("square low bits not masked");
  AST_SQ3_ROW_QUIET: assert property (settled && mode == `TMG_MODE_SQ3
    |-> row_dac == `TMG_DAC_MID) else $error("row tone present in square 3");
  AST_PAC_IDLE: assert property (settled && !mode[1] |-> pacifier_out) else $error("pacifier active");
  AST_PAC_ROW_MSB: assert property (settled && mode == `TMG_MODE_SQ2 && $stable(row_dac)
    |-> pacifier_out == row_dac[5]) else $error("pacifier not row msb");
  AST_ROW_OFF: assert property (settled && !ctl[`TMG_CTL_ROW_EN]
    |-> row_dac == `TMG_DAC_MID) else $error("row path runs while off");
  AST_COL_OFF: assert property (settled && !ctl[`TMG_CTL_COL_EN]
    |-> col_dac == `TMG_DAC_MID) else $error("column path runs while off");

  cover property (pslverr);
  cover property (settled && mode == `TMG_MODE_SQ2 && $rose(pacifier_out));
  cover property (settled && mode == `TMG_MODE_SINE && ctl[`TMG_CTL_ROW_EN] && $changed(row_dac));
endmodule

bind tmg_top tmg_top_monitor i_mon (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .stop_mode(stop_mode),
  .row_dac(row_dac),
  .col_dac(col_dac),
  .tone_out_oe_n(tone_out_oe_n),
  .pacifier_out(pacifier_out)
);

// ==== dv/tmg_far_side.sv ====
`timescale 1ns/1ps

// behavioural ladder, filter and speaker at the tone pins
module tmg_far_side (
  input wire pclk,
  input wire [5:0] row_dac,
  input wire [5:0] col_dac,
  input wire tone_out_oe_n,
  input wire pacifier_out,
  output logic [7:0] tone_level,
  output logic speaker
);
  logic [7:0] last = 8'h00;
  // row current cut by about 2 dB, then summed with column current
  wire [7:0] sum = 8'((row_dac * 13) >> 4) + {2'h0, col_dac};

  // a released tone pin shows the inverse of its last driven level
  always @(posedge pclk) begin
    if (!tone_out_oe_n) begin
      last <= sum;
    end
  end
  assign tone_level = tone_out_oe_n ? ~last : last;
  assign speaker = pacifier_out; // pacifier reaches the speaker unfiltered
endmodule

// ==== dv/tmg_top_test.sv ====
`timescale 1ns/1ps
`include "tmg_consts.vh"

module tmg_top_test;
  localparam int TD = 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic stop_mode = 1'b0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire tone_out_oe_n;
  wire pacifier_out;
  wire speaker;
  wire [5:0] row_dac;
  wire [5:0] col_dac;
  wire [7:0] tone_level;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int cyc;
  logic [31:0] rd;
  logic err;
  logic [5:0] v1;
  logic [5:0] sine [28] = '{6'h20, 6'h27, 6'h2D, 6'h33, 6'h38, 6'h3C, 6'h3E, 6'h3F, 6'h3E, 6'h3C, 6'h38, 6'h33,
    6'h2D, 6'h27, 6'h1F, 6'h19, 6'h13, 6'h0D, 6'h08, 6'h04, 6'h02, 6'h01, 6'h02, 6'h04, 6'h08, 6'h0D, 6'h13, 6'h19};

  tmg_top #(.TONE_DIV(TD)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .row_dac(row_dac), .col_dac(col_dac), .tone_out_oe_n(tone_out_oe_n),
    .pacifier_out(pacifier_out));
  tmg_far_side i_far (.pclk(pclk), .row_dac(row_dac), .col_dac(col_dac), .tone_out_oe_n(tone_out_oe_n),
    .pacifier_out(pacifier_out), .tone_level(tone_level), .speaker(speaker));

  always #25 pclk = ~pclk;

  // cycle ceiling against hangs
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // pready ends this wait; the bench's cycle ceiling catches a hang
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait for a change on row (0), column (1) or pacifier (2)
  task wchg(input int sel, input int lim);
    logic [5:0] v;
    v = sel == 0 ? row_dac : sel == 1 ? col_dac : {5'h00, pacifier_out};
    cyc = 0;
    do begin
      @(posedge pclk);
      #1;
      cyc++;
    end while ((sel == 0 ? row_dac : sel == 1 ? col_dac : {5'h00, pacifier_out}) === v && cyc < lim);
  endtask

  task hold_idle(input int n);
    repeat (n) begin
      @(posedge pclk);
      #1;
      chk({pacifier_out, row_dac, col_dac}, 13'h1820);
    end
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TMG_ADDR_CONTROL, 32'h0);
    chk(rd, 32'h0);
    chk({tone_out_oe_n, pacifier_out, row_dac, col_dac}, 14'h3820);
    apb(1'b1, `TMG_ADDR_ROW_CODE, 32'hFF);
    apb(1'b0, `TMG_ADDR_ROW_CODE, 32'h0);
    chk(rd, 32'h1F);
    apb(1'b1, `TMG_ADDR_CONTROL, 32'hFF);
    apb(1'b0, `TMG_ADDR_CONTROL, 32'h0);
    chk(rd, 32'hF8);
    apb(1'b0, 12'h100, 32'h0);
    chk(err, 1'b1);
    // row code in column register keeps every output idle
    hold_idle(800);
    chk({tone_out_oe_n, tone_level}, 9'h03A);
    apb(1'b0, `TMG_ADDR_STATUS, 32'h0);
    chk(rd, 32'h8);
    apb(1'b1, `TMG_ADDR_ROW_CODE, 32'h12);
    apb(1'b1, `TMG_ADDR_COL_CODE, 32'h14);
    hold_idle(800);
    // legal codes go in with both paths off, then both paths start together
    apb(1'b1, `TMG_ADDR_CONTROL, 32'h08);
    apb(1'b1, `TMG_ADDR_ROW_CODE, 32'h1F);
    apb(1'b1, `TMG_ADDR_COL_CODE, 32'h10);
    apb(1'b1, `TMG_ADDR_CONTROL, 32'h38);
    // sine staircase on the row path from its reset step
    for (int i = 1; i <= 28; i++) begin
      wchg(0, 200);
      chk(row_dac, sine[i % 28]);
      if (i > 1)
        chk(cyc, 27 * TD);
    end
    // square 1: msb only, half period of 14 steps
    apb(1'b1, `TMG_ADDR_CONTROL, 32'h78);
    wchg(0, 2000);
    v1 = row_dac;
    wchg(0, 2000);
    chk(cyc, 14 * 27 * TD);
    chk(row_dac, v1 ^ 6'h20);
    chk(pacifier_out, 1'b1);
    apb(1'b0, `TMG_ADDR_STATUS, 32'h0);
    chk(rd, 32'hF);
    apb(1'b1, `TMG_ADDR_CONTROL, 32'hB8);
    wchg(0, 2000);
    chk(pacifier_out, row_dac[5]);
    apb(1'b1, `TMG_ADDR_CONTROL, 32'hF8);
    wchg(1, 2000);
    chk({row_dac, col_dac[4:0]}, 11'h400);
    wchg(2, 2000);
    chk(cyc < 2000, 1'b1);
    // square 3 with the row path off: pacifier stays at its idle level
    apb(1'b1, `TMG_ADDR_CONTROL, 32'hD8);
    repeat (2) @(posedge pclk);
    wchg(2, 800);
    chk(cyc, 800);
    @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk({tone_out_oe_n, pacifier_out, speaker}, 3'h7);
    @(posedge pclk);
    stop_mode <= 1'b0;
    apb(1'b1, `TMG_ADDR_CONTROL, 32'h08);
    repeat (3) @(posedge pclk);
    #1;
    chk({tone_out_oe_n, row_dac, col_dac, tone_level}, 21'h08203A);
    test_done();
  end
endmodule
